// ---- rtl/pbl_regs.sv ----
// Purpose: Device status, link capabilities and link control registers
//          of a PCI Express to PCI bridge, reached by configuration access.
// Assumes: Single core_clk domain; error and nonposted events are
//          same-domain pulses; the aux power level comes from a pin.
// Notes:   Reads return one cycle after the request.
//
// Contract
// RULE_01: Device status bits 15:6 always read zero.
// RULE_02: Bit 5 set while any issued nonposted request awaits completion.
// RULE_03: Bit 4 reflects the detected auxiliary power input.
// RULE_04: Bit 3 sets on unsupported request, sticky until software clear.
// RULE_05: Bit 2 sets on fatal error, sticky until software clear.
// RULE_06: Bit 1 sets on nonfatal error, sticky until software clear.
// RULE_07: Bit 0 sets on correctable error, sticky until software clear.
// RULE_08: Link capabilities bits 31:24 read zero, port 0.
// RULE_09: Link capabilities bits 23:18 read zero.
// RULE_10: L1 exit time taken from diag 20:18 if shared clock, else 17:15; code takes diag_l1_exit_sep_clk when shared.
// RULE_11: Shared reference clock reports L0s exit time 011b.
// RULE_12: Separate reference clocks report L0s exit time 100b.
// RULE_13: Active PM support field reads 11b.
// RULE_14: Max lane count field reads 000001b.
// RULE_15: Top link rate field reads 1h.
// RULE_16: Link control bit 6 set means shared clock, clear separate.
// RULE_17: Writing 1 clears an error flag; same-cycle detection keeps it.
// RULE_18: Outstanding flag clears once all nonposted completions return.
`timescale 1ns/1ps
`default_nettype none
`include "pbl_map.svh"

module pbl_regs (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Configuration access port
  input  wire logic                 cfg_rd,
  input  wire logic                 cfg_wr,
  input  wire logic [7:0]           cfg_addr,
  input  wire logic [3:0]           cfg_be,
  input  wire logic [31:0]          cfg_wdata,
  output logic [31:0]               cfg_rdata,
  output logic                      cfg_rvalid,
  // Bridge core events
  input  wire pbl_pkg::pbl_err_evt_s err_evt,
  input  wire logic                 np_issue,
  input  wire logic                 np_complete,
  input  wire logic                 aux_power_pin,
  // Diagnostic L1 exit time sources
  input  wire logic [2:0]           diag_l1_exit_sep_clk,
  input  wire logic [2:0]           diag_l1_exit_shared_clk,
  // Status views for the core
  output logic                      outstanding_request_flag,
  output logic                      shared_refclk
);
  import pbl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State
  pbl_state_s     st_q;
  pbl_state_s     st_d;
  pbl_link_caps_s caps;
  logic [15:0]    dev_status;
  logic           wr_status;
  logic           wr_ctrl;
  logic [3:0]     clr_err;
  logic [`PBL_NP_CNT_W-1:0] np_max;

  ////////////////////////////////////////////////////////////////////////
  // Read views
  // Capabilities are wired, not stored, so they follow the clock bit
  always_comb begin
    caps.port_idx                = `PBL_LCAP_PORT_IDX;        // RULE_08
    caps.rsvd                    = `PBL_LCAP_RSVD;            // RULE_09
    caps.l1_exit_time            = st_q.link_ctrl[`PBL_LC_SHARED_BIT]
                                 ? diag_l1_exit_sep_clk
                                 : diag_l1_exit_shared_clk;   // RULE_10
    caps.l0s_exit_time           = st_q.link_ctrl[`PBL_LC_SHARED_BIT]
                                 ? `PBL_L0S_SHARED            // RULE_11
                                 : `PBL_L0S_SEPARATE;         // RULE_12
    caps.active_pm_support_level = `PBL_ASPM_SUPPORT;         // RULE_13
    caps.max_lane_count          = `PBL_MAX_LANES;            // RULE_14
    caps.top_link_rate           = `PBL_TOP_RATE;             // RULE_15
  end

  // Device status assembly; upper bits never stored
  always_comb begin
    dev_status = `PBL_DS_RESET;                                // RULE_01
    dev_status[`PBL_DS_OUTSTANDING_REQUEST_FLAG_BIT]     = st_q.np_cnt != '0;      // RULE_02
    dev_status[`PBL_DS_AUX_BIT]      = st_q.aux_sync;          // RULE_03
    dev_status[`PBL_DS_UNSUP_BIT]    = st_q.unsupported_req_seen;
    dev_status[`PBL_DS_FATAL_BIT]    = st_q.fatal_err_seen;
    dev_status[`PBL_DS_NONFATAL_BIT] = st_q.nonfatal_err_seen;
    dev_status[`PBL_DS_CORR_BIT]     = st_q.correctable_err_seen;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  // All writable bits sit in byte lane 0
  assign wr_status = cfg_wr && cfg_be[0] && (cfg_addr == `PBL_OFS_DEV_STATUS);
  assign wr_ctrl   = cfg_wr && cfg_be[0] && (cfg_addr == `PBL_OFS_LINK_CTRL);
  assign clr_err   = wr_status ? cfg_wdata[3:0] : 4'h0;      // RULE_17
  assign np_max    = '1;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    // Two-stage synchroniser for the aux pin
    st_d.aux_meta = aux_power_pin;
    st_d.aux_sync = st_q.aux_meta;                            // RULE_03
    // Set beats clear so a detection never slips by
    st_d.correctable_err_seen = err_evt.correctable_err ||
      (st_q.correctable_err_seen && !clr_err[`PBL_DS_CORR_BIT]);   // RULE_07
    st_d.nonfatal_err_seen = err_evt.nonfatal_err ||
      (st_q.nonfatal_err_seen && !clr_err[`PBL_DS_NONFATAL_BIT]);  // RULE_06
    st_d.fatal_err_seen = err_evt.fatal_err ||
      (st_q.fatal_err_seen && !clr_err[`PBL_DS_FATAL_BIT]);        // RULE_05
    st_d.unsupported_req_seen = err_evt.unsupported_req ||
      (st_q.unsupported_req_seen && !clr_err[`PBL_DS_UNSUP_BIT]);  // RULE_04
    // Outstanding count; saturates rather than wrap to a false idle
    if (np_issue && !np_complete && st_q.np_cnt != np_max) begin
      st_d.np_cnt = st_q.np_cnt + 1'b1;                       // RULE_02
    end else if (np_complete && !np_issue && st_q.np_cnt != '0) begin
      st_d.np_cnt = st_q.np_cnt - 1'b1;                       // RULE_18
    end
    // Only implemented link control bits take writes
    if (wr_ctrl) begin
      st_d.link_ctrl = cfg_wdata[15:0] & `PBL_LC_WR_MASK;     // RULE_16
    end
    // Read answer, registered; unmapped offsets return zero
    st_d.rvalid = cfg_rd;
    if (cfg_rd) begin
      case (cfg_addr)
        `PBL_OFS_DEV_STATUS: st_d.rdata = {16'h0000, dev_status};
        `PBL_OFS_LINK_CAPS:  st_d.rdata = caps;
        `PBL_OFS_LINK_CTRL:  st_d.rdata = {16'h0000, st_q.link_ctrl};
        default:             st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cfg_rdata                = st_q.rdata;
  assign cfg_rvalid               = st_q.rvalid;
  assign outstanding_request_flag = st_q.np_cnt != '0;
  assign shared_refclk            = st_q.link_ctrl[`PBL_LC_SHARED_BIT];

endmodule : pbl_regs
`default_nettype wire

// ---- rtl/pbl_map.svh ----
// Purpose: Offsets, field positions, reset values and fixed codes for the
//          device status, link capabilities and link control registers.
// Assumes: Included by the package and the register module.
// Notes:   Definitions only.
`ifndef PBL_MAP_SVH
`define PBL_MAP_SVH

// Configuration offsets as printed (byte addresses)
`define PBL_OFS_DEV_STATUS  8'h9A
`define PBL_OFS_LINK_CAPS   8'h9C
`define PBL_OFS_LINK_CTRL   8'hA0

// Device status fields
`define PBL_DS_CORR_BIT     0
`define PBL_DS_NONFATAL_BIT 1
`define PBL_DS_FATAL_BIT    2
`define PBL_DS_UNSUP_BIT    3
`define PBL_DS_AUX_BIT      4
`define PBL_DS_OUTSTANDING_REQUEST_FLAG_BIT     5
`define PBL_DS_RESET        16'h0000

// Link control: writable bits and the shared-refclk bit
`define PBL_LC_SHARED_BIT   6
`define PBL_LC_WR_MASK      16'h00CB
`define PBL_LC_RESET        16'h0000

// Link capabilities fixed fields
`define PBL_LCAP_PORT_IDX   8'h00
`define PBL_LCAP_RSVD       6'h00
`define PBL_L0S_SHARED      3'h3
`define PBL_L0S_SEPARATE    3'h4
`define PBL_ASPM_SUPPORT    2'h3
`define PBL_MAX_LANES       6'h01
`define PBL_TOP_RATE        4'h1

// Outstanding nonposted counter width
`define PBL_NP_CNT_W        6

`endif

// ---- rtl/pbl_pkg.sv ----
// Purpose: Types shared by the register logic and its bench.
// Assumes: pbl_map.svh defines the constants.
// Notes:   State and the error event group travel as packed structs.
`include "pbl_map.svh"

package pbl_pkg;

  // One-cycle error detections from the bridge core
  typedef struct packed {
    logic unsupported_req;
    logic fatal_err;
    logic nonfatal_err;
    logic correctable_err;
  } pbl_err_evt_s;

  // Link capabilities layout
  typedef struct packed {
    logic [7:0] port_idx;
    logic [5:0] rsvd;
    logic [2:0] l1_exit_time;
    logic [2:0] l0s_exit_time;
    logic [1:0] active_pm_support_level;
    logic [5:0] max_lane_count;
    logic [3:0] top_link_rate;
  } pbl_link_caps_s;

  // Whole module state
  typedef struct packed {
    logic [`PBL_NP_CNT_W-1:0] np_cnt;
    logic                     unsupported_req_seen;
    logic                     fatal_err_seen;
    logic                     nonfatal_err_seen;
    logic                     correctable_err_seen;
    logic                     aux_meta;
    logic                     aux_sync;
    logic [15:0]              link_ctrl;
    logic [31:0]              rdata;
    logic                     rvalid;
  } pbl_state_s;

endpackage : pbl_pkg

// ---- testbench/pbl_regs_monitor.sv ----
// Purpose: Port checker for pbl_regs.
// Assumes: One core_clk domain, rstn async low.
// Notes:   Bound into every pbl_regs.
`timescale 1ns/1ps
`default_nettype none
module pbl_regs_monitor (
  input wire logic                 core_clk,
  input wire logic                 rstn,
  input wire logic                 cfg_rd,
  input wire logic                 cfg_wr,
  input wire logic [7:0]           cfg_addr,
  input wire logic [3:0]           cfg_be,
  input wire logic [31:0]          cfg_wdata,
  input wire logic [31:0]          cfg_rdata,
  input wire logic                 cfg_rvalid,
  input wire pbl_pkg::pbl_err_evt_s err_evt,
  input wire logic                 np_issue,
  input wire logic                 np_complete,
  input wire logic                 outstanding_request_flag,
  input wire logic                 shared_refclk
);
  import pbl_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic rd_s;
  logic rd_c;
  // Reads of status and caps; answer lands one edge later
  assign rd_s = cfg_rd && cfg_addr == 8'h9A;
  assign rd_c = cfg_rd && cfg_addr == 8'h9C;
  a_rsvd_zero: assert property (
    rd_s |=> cfg_rvalid && cfg_rdata[31:6] == 0) else $error("rsvd set");
  a_outstanding_request_flag_read: assert property (
    rd_s |=> cfg_rdata[5] == $past(outstanding_request_flag))
    else $error("pending bit wrong");
  a_outstanding_request_flag_set: assert property (
    np_issue && !np_complete |=> outstanding_request_flag)
    else $error("pending not set");
  a_outstanding_request_flag_drop: assert property (
    $fell(outstanding_request_flag) |-> $past(np_complete && !np_issue))
    else $error("pending dropped early");
  a_err_sticky: assert property (
    |err_evt ##1 rd_s |=>
      (cfg_rdata[3:0] & $past(err_evt, 2)) == $past(err_evt, 2))
    else $error("error flag lost");
  a_lc_write: assert property (
    cfg_wr && cfg_addr == 8'hA0 && cfg_be[0] |=>
      shared_refclk == $past(cfg_wdata[6])) else $error("clock bit");
  a_l0s_code: assert property (
    rd_c |=> cfg_rdata[14:12] == ($past(shared_refclk) ? 3'h3 : 3'h4))
    else $error("l0s code wrong");
  a_caps_fixed: assert property (
    rd_c |=> cfg_rdata[31:18] == 0 && cfg_rdata[11:0] == 12'hC11)
    else $error("caps fixed field");
  c_shared_rd: cover property (rd_c && shared_refclk);
  c_np_both: cover property (np_issue && np_complete);
  c_clear_evt: cover property (|err_evt && cfg_wr);
endmodule : pbl_regs_monitor
bind pbl_regs pbl_regs_monitor u_mon (.*);
`default_nettype wire

// ---- testbench/pbl_host_model.sv ----
// Purpose: Host software issuing configuration accesses.
// Assumes: Tasks are entered just after a falling edge.
// Notes:   Released lines show inverted data; wr leaves cfg_addr at the written offset.
`timescale 1ns/1ps
`default_nettype none
module pbl_host_model (
  input  wire logic        core_clk,
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic [7:0]       cfg_addr,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid
);
  // Idle bus from time zero
  initial begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0;
  end
  // Answer must be there one edge after the request
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge core_clk);
    d = cfg_rvalid ? cfg_rdata : 32'hXXXX_XXXX;
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    @(negedge core_clk);
  endtask : rd
  // A one clears an error flag, a zero leaves it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
    @(negedge core_clk);
  endtask : wr
endmodule : pbl_host_model
`default_nettype wire

// ---- testbench/test_pcie_bridge_dev_status_link_caps.sv ----
// Purpose: Self-checking bench for pbl_regs.
// Assumes: 200 MHz core_clk, inputs move on falling edges.
// Notes:   Host model makes every configuration access.
`timescale 1ns/1ps
`default_nettype none
module test_pcie_bridge_dev_status_link_caps;
  import pbl_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, cfg_rd, cfg_wr, cfg_rvalid;
  logic np_issue = 1'b0, np_complete = 1'b0, aux_power_pin = 1'b0;
  logic outstanding_request_flag, shared_refclk;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be = 4'h1;
  logic [31:0] cfg_wdata, cfg_rdata, rd_data;
  logic [2:0] diag_l1_exit_sep_clk = 3'h5, diag_l1_exit_shared_clk = 3'h2;
  pbl_err_evt_s err_evt = '0;
  int miscompares = 0, total_checks = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  pbl_regs dut (.*);
  pbl_host_model host (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    host.rd(a, rd_data);
    chk(rd_data, exp);
  endtask : rc
  // Expected caps word; the clock setting picks both latencies
  function automatic logic [31:0] caps(input logic sh);
    return {14'h0, sh ? diag_l1_exit_sep_clk : diag_l1_exit_shared_clk,
            sh ? 3'h3 : 3'h4, 12'hC11};
  endfunction : caps
  task automatic t_caps;
    rc(8'h9A, 32'h0);
    rc(8'h9C, caps(1'b0));
    host.wr(8'hA0, 32'hFFFF_FFFF);
    chk({31'h0, shared_refclk}, 32'h1);
    rc(8'hA0, 32'h0000_00CB);
    rc(8'h9C, caps(1'b1));
    host.wr(8'h9C, 32'h0);
    host.wr(8'hA0, 32'h0);
    chk({31'h0, shared_refclk}, 32'h0);
    rc(8'h9C, caps(1'b0));
    rc(8'h9E, 32'h0);
    $display("caps test done");
  endtask : t_caps
  task automatic t_err;
    for (int i = 0; i < 4; i++) begin
      err_evt = pbl_err_evt_s'(4'h1 << i);
      @(negedge core_clk);
      err_evt = '0;
      rc(8'h9A, 32'h1 << i);
      host.wr(8'h9A, 32'h0);
      rc(8'h9A, 32'h1 << i);
      // Detection in the clearing cycle must win
      err_evt = pbl_err_evt_s'(4'h1 << i);
      fork
        host.wr(8'h9A, 32'h1 << i);
        begin @(negedge core_clk); err_evt = '0; end
      join
      rc(8'h9A, 32'h1 << i);
      host.wr(8'h9A, 32'h1 << i);
      rc(8'h9A, 32'h0);
    end
    $display("error flag test done");
  endtask : t_err
  task automatic t_outstanding_request_flag;
    np_issue = 1'b1;
    repeat (2) @(negedge core_clk);
    np_complete = 1'b1;
    @(negedge core_clk);
    np_issue = 1'b0;
    @(negedge core_clk);
    np_complete = 1'b0;
    chk({31'h0, outstanding_request_flag}, 32'h1);
    rc(8'h9A, 32'h20);
    np_complete = 1'b1;
    @(negedge core_clk);
    np_complete = 1'b0;
    chk({31'h0, outstanding_request_flag}, 32'h0);
    rc(8'h9A, 32'h0);
    aux_power_pin = 1'b1;
    repeat (2) @(negedge core_clk);
    rc(8'h9A, 32'h10);
    aux_power_pin = 1'b0;
    repeat (2) @(negedge core_clk);
    rc(8'h9A, 32'h0);
    $display("pending and aux test done");
  endtask : t_outstanding_request_flag
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    t_caps();
    t_err();
    t_outstanding_request_flag();
    print_verdict();
  end
  // Hang guard, far beyond the hundred or so cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      print_verdict();
    end
  end
endmodule : test_pcie_bridge_dev_status_link_caps
`default_nettype wire
